// ---- rtl/uirlp_lp_clkgen.sv ----
/*
  Low-power baud clock generator: a divide-by-divisor prescaler giving a
  sixteen-times tick, then a divide-by-sixteen giving the baud tick.
  Assumes divisor is stable except where restart is pulsed with its change.
*/
`timescale 1ns/100ps

module uirlp_lp_clkgen #(
  parameter int DIV_W = 16
) (
  // clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic restart,
  input wire logic [DIV_W-1:0] divisor,
  // ticks
  output logic sub_tick,
  output logic baud_tick
);

  logic [DIV_W-1:0] sub_cnt_reg;
  logic [3:0] phase_reg;
  logic sub_tick_reg;
  logic baud_tick_reg;

  wire logic clk_on = (divisor != '0);
  wire logic sub_hit = (sub_cnt_reg == divisor - DIV_W'(1));
  wire logic [DIV_W-1:0] sub_cnt_next = sub_hit ? '0 : sub_cnt_reg + DIV_W'(1);
  wire logic last_phase = (phase_reg == uirlp_pkg::SUB_PER_BAUD_LAST);

  // the prescaler needs at least one divisor bit to count with
  if (DIV_W < 1) begin : gen_bad_width
    $error("divisor width must be at least one bit");
  end

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  // a divisor change restarts the phase so the first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_cnt_reg <= '0;
      phase_reg <= 4'h0;
      sub_tick_reg <= 1'b0;
      baud_tick_reg <= 1'b0;
    end else if (ce) begin
      if (restart || !clk_on) begin
        sub_cnt_reg <= '0;
        phase_reg <= 4'h0;
        sub_tick_reg <= 1'b0;
        baud_tick_reg <= 1'b0;
      end else begin
        sub_cnt_reg <= sub_cnt_next;
        sub_tick_reg <= sub_hit;
        baud_tick_reg <= sub_hit && last_phase;
        if (sub_hit) begin
          phase_reg <= phase_reg + 4'h1;
        end
      end
    end
  end

  assign sub_tick = sub_tick_reg;
  assign baud_tick = baud_tick_reg;

endmodule : uirlp_lp_clkgen

// ---- rtl/uirlp_pkg.sv ----
/*
  Shared constants for the infrared low-power divisor block: register
  addresses, field positions, reset values, timing counts and state types.
  Assumes a 32-bit APB bus with byte addresses and one word per register.
*/
package uirlp_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] DIV_LO_ADDR = 32'h5000_1120;
  localparam logic [31:0] DIV_HI_ADDR = 32'h5000_1124;
  localparam logic [31:0] LINE_CTRL_ADDR = 32'h5000_1128;
  localparam logic [31:0] STATUS_ADDR = 32'h5000_112C;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int DIV_W = 16;
  localparam int LATCH_ACCESS_BIT = 7;
  localparam logic [7:0] DIV_BYTE_RESET = 8'h00;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam int STAT_LEVEL_BIT = 0;
  localparam int STAT_CLK_ON_BIT = 1;
  localparam int STAT_SETTLE_BIT = 2;
  localparam int STAT_SEEN_BIT = 3;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [3:0] SETTLE_CYCLES = 4'h8;
  localparam logic [3:0] SUB_PER_BAUD_LAST = 4'hF;
  localparam logic [3:0] MIN_PULSE_SUB = 4'h3;

  // ---------------------------------------------------------------
  // pulse detector states
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    PD_IDLE,
    PD_MEASURE
  } uirlp_pd_e;

endpackage : uirlp_pkg

// ---- rtl/uirlp_top.sv ----
/*
  APB register block holding the 16-bit low-power infrared divisor, the
  low-power baud clock made from it and the minimum pulse width detector
  on the infrared receive input.
  Assumes an APB master on pclk and an asynchronous infrared input pin.
*/
// Register access over APB is this design's own decision.
`timescale 1ns/100ps

module uirlp_top (
  // clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // infrared receive side
  input wire logic sir_in,
  input wire logic sir_lp_mode,
  // status outputs
  output logic lp_baud_tick,
  output logic lp_clk_enabled,
  output logic sir_pulse_detected,
  output logic settle_busy,
  output logic [15:0] lp_divisor
);

  localparam int DW = uirlp_pkg::DIV_W;
  localparam int NBYTES = DW / uirlp_pkg::BYTE_W;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [7:0] line_ctrl_reg;
  logic prep_reg;
  logic [31:0] prdata_reg;
  logic err_reg;
  logic [3:0] settle_reg;
  logic pulse_seen_reg;
  logic sir_level_reg;
  logic sub_tick;
  wire logic [DW-1:0] divisor;

  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic sel_lo = (paddr == uirlp_pkg::DIV_LO_ADDR);
  wire logic sel_hi = (paddr == uirlp_pkg::DIV_HI_ADDR);
  wire logic sel_ctrl = (paddr == uirlp_pkg::LINE_CTRL_ADDR);
  wire logic sel_stat = (paddr == uirlp_pkg::STATUS_ADDR);
  wire logic [NBYTES-1:0] sel_byte = {sel_hi, sel_lo};
  wire logic sel_div = sel_lo || sel_hi;
  wire logic mapped = sel_div || sel_ctrl || sel_stat;
  wire logic divisor_latch_access_bit = line_ctrl_reg[uirlp_pkg::LATCH_ACCESS_BIT];
  wire logic locked = sel_div && !divisor_latch_access_bit;
  wire logic bad_access = !mapped || locked;

  // ---------------------------------------------------------------
  // transfer timing
  // ---------------------------------------------------------------
  // read data is caught at the setup edge; pready waits for that catch,
  // so a setup cycle with ce low simply adds wait states
  assign pready = access && prep_reg && ce;
  assign pslverr = pready && err_reg;
  assign prdata = prdata_reg;

  wire logic done = access && pready;
  wire logic wr_fire = done && pwrite && !err_reg;
  wire logic rd_fire = done && !pwrite;
  wire logic div_wr = wr_fire && sel_div && pstrb[0];
  wire logic stat_rd = rd_fire && sel_stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prep_reg <= 1'b0;
    end else if (ce) begin
      prep_reg <= setup || (access && !prep_reg);
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire logic [7:0] status_byte = {
    4'h0,
    pulse_seen_reg,
    settle_busy,
    lp_clk_enabled,
    sir_level_reg
  };
  wire logic [7:0] rd_byte =
    sel_lo ? divisor[7:0] :
    sel_hi ? divisor[15:8] :
    sel_ctrl ? line_ctrl_reg :
    sel_stat ? status_byte : 8'h00;
  // reserved upper bits and refused reads give zero
  wire logic [31:0] rd_next = bad_access ? 32'h0000_0000 : {24'h00_0000, rd_byte};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (ce && (setup || (access && !prep_reg))) begin
      prdata_reg <= rd_next;
      err_reg <= bad_access;
    end
  end

  // ---------------------------------------------------------------
  // divisor bytes and line control
  // ---------------------------------------------------------------
  for (genvar b = 0; b < NBYTES; b++) begin : gen_byte
    logic [7:0] byte_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        byte_reg <= uirlp_pkg::DIV_BYTE_RESET;
      end else if (ce && div_wr && sel_byte[b]) begin
        byte_reg <= pwdata[7:0];
      end
    end
    assign divisor[b*8 +: 8] = byte_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ctrl_reg <= uirlp_pkg::LINE_CTRL_RESET;
    end else if (ce && wr_fire && sel_ctrl && pstrb[0]) begin
      line_ctrl_reg <= pwdata[7:0];
    end
  end

  assign lp_divisor = divisor;
  assign lp_clk_enabled = (divisor != '0);

  // ---------------------------------------------------------------
  // settle window after a divisor write
  // ---------------------------------------------------------------
  // software is only advised to wait; this count lets it poll instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 4'h0;
    end else if (ce) begin
      if (div_wr) begin
        settle_reg <= uirlp_pkg::SETTLE_CYCLES;
      end else if (settle_reg != 4'h0) begin
        settle_reg <= settle_reg - 4'h1;
      end
    end
  end

  assign settle_busy = (settle_reg != 4'h0);

  // ---------------------------------------------------------------
  // low-power baud clock
  // ---------------------------------------------------------------
  uirlp_lp_clkgen #(
    .DIV_W(DW)
  ) u_clkgen (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .restart(div_wr),
    .divisor(divisor),
    .sub_tick(sub_tick),
    .baud_tick(lp_baud_tick)
  );

  // ---------------------------------------------------------------
  // receive input synchroniser
  // ---------------------------------------------------------------
  logic sir_s1_reg;
  logic sir_s2_reg;
  logic sir_s3_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sir_s1_reg <= 1'b0;
      sir_s2_reg <= 1'b0;
      sir_s3_reg <= 1'b0;
      sir_level_reg <= 1'b0;
    end else if (ce) begin
      sir_s1_reg <= sir_in;
      sir_s2_reg <= sir_s1_reg;
      sir_s3_reg <= sir_s2_reg;
      if (sir_s2_reg == sir_s3_reg) begin
        sir_level_reg <= sir_s3_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // pulse width detector
  // ---------------------------------------------------------------
  uirlp_pkg::uirlp_pd_e pd_state_reg;
  uirlp_pkg::uirlp_pd_e pd_state_next;
  logic [3:0] width_reg;
  logic pulse_det_reg;

  wire logic det_en = lp_clk_enabled;
  wire logic wide_enough = !sir_lp_mode || (width_reg >= uirlp_pkg::MIN_PULSE_SUB);
  wire logic pulse_end = (pd_state_reg == uirlp_pkg::PD_MEASURE) && det_en && !sir_level_reg;
  wire logic accept = pulse_end && wide_enough;

  always_comb begin
    pd_state_next = pd_state_reg;
    case (pd_state_reg)
      uirlp_pkg::PD_IDLE: begin
        if (det_en && sir_level_reg) begin
          pd_state_next = uirlp_pkg::PD_MEASURE;
        end
      end
      uirlp_pkg::PD_MEASURE: begin
        if (!det_en || !sir_level_reg) begin
          pd_state_next = uirlp_pkg::PD_IDLE;
        end
      end
      default: pd_state_next = uirlp_pkg::PD_IDLE;
    endcase
  end

  // width counts sixteen-times ticks and saturates, so long pulses pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_state_reg <= uirlp_pkg::PD_IDLE;
      width_reg <= 4'h0;
      pulse_det_reg <= 1'b0;
    end else if (ce) begin
      pd_state_reg <= pd_state_next;
      pulse_det_reg <= accept;
      if (pd_state_reg == uirlp_pkg::PD_IDLE) begin
        width_reg <= 4'h0;
      end else if (sub_tick && width_reg != 4'hF) begin
        width_reg <= width_reg + 4'h1;
      end
    end
  end

  assign sir_pulse_detected = pulse_det_reg;

  // sticky seen flag: a new pulse beats a clearing status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_seen_reg <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        pulse_seen_reg <= 1'b1;
      end else if (stat_rd) begin
        pulse_seen_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [19:0] gap_reg;
  logic gap_ok_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 20'h0_0000;
      gap_ok_reg <= 1'b0;
    end else if (ce) begin
      if (div_wr || lp_baud_tick) begin
        gap_reg <= 20'h0_0000;
        gap_ok_reg <= !div_wr;
      end else begin
        gap_reg <= gap_reg + 20'h0_0001;
      end
    end
  end

  a_low_byte_write: assert property (
    (ce && div_wr && sel_lo) |=> (divisor[7:0] == $past(pwdata[7:0])) && $stable(divisor[15:8]))
    else $error("low divisor byte not written");
  a_high_byte_write: assert property (
    (ce && div_wr && sel_hi) |=> (divisor[15:8] == $past(pwdata[7:0])) && $stable(divisor[7:0]))
    else $error("high divisor byte not written");
  a_locked_divisor: assert property (
    (done && sel_div && !divisor_latch_access_bit) |-> pslverr ##1 $stable(divisor))
    else $error("divisor reachable without latch access");
  a_baud_period: assert property (
    (lp_baud_tick && gap_ok_reg) |-> (gap_reg == ({divisor, 4'h0} - 20'h0_0001)))
    else $error("baud tick period wrong");
  a_min_width: assert property (
    (sir_pulse_detected && $past(sir_lp_mode)) |-> ($past(width_reg) >= 4'h3))
    else $error("short pulse accepted in low-power mode");
  a_zero_quiet: assert property (
    (divisor == '0) |-> (!lp_baud_tick && !sub_tick && pd_state_reg == uirlp_pkg::PD_IDLE))
    else $error("activity with zero divisor");
  a_settle_hold: assert property (
    (ce && div_wr) |=> settle_busy && (settle_reg == 4'h8))
    else $error("settle window not started");
  a_reserved_zero: assert property (
    (rd_fire && sel_div) |-> (prdata[31:8] == 24'h00_0000))
    else $error("reserved divisor bits not zero");

  c_divisor_write: cover property (ce && div_wr && divisor_latch_access_bit);
  c_baud_tick: cover property (lp_baud_tick && gap_ok_reg);
  c_pulse_accept: cover property (sir_pulse_detected && sir_lp_mode);
  c_locked_error: cover property (pslverr && locked);

endmodule : uirlp_top

// ---- test/uirlp_ir_xcvr.sv ----
/*
  Behavioural infrared transceiver on the receive line: on go it drives
  one active-high pulse of width pclk cycles onto sir_in.
  Assumes go is a one-cycle request driven at the rising edge.
*/
`timescale 1ns/100ps

module uirlp_ir_xcvr (
  // clock
  input wire logic pclk,
  // request
  input wire logic go,
  input wire logic [7:0] width,
  // receive line
  output logic sir_in
);
  int left = 0;

  always @(posedge pclk) begin
    if (go && left == 0) begin
      left <= width;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end

  // idle low between pulses, the receiver reads active-high pulses
  assign sir_in = (left > 0);
endmodule : uirlp_ir_xcvr

// ---- test/uirlp_top_bench.sv ----
/*
  Self-checking bench for the low-power divisor block: APB register
  access, baud tick spacing, pulse-width filtering and zero divisor.
  Assumes the design answers APB with pready and runs on a 40 MHz pclk.
*/
`timescale 1ns/100ps

module uirlp_top_bench;
  logic pclk, presetn, ce, psel, penable, pwrite, sir_lp_mode, sir_in, go;
  logic [31:0] paddr, pwdata, prdata, rd, wd;
  logic [3:0] pstrb, st;
  logic [7:0] width, lo, hi, b;
  logic pready, pslverr, lp_baud_tick, lp_clk_enabled, sir_pulse_detected;
  logic settle_busy, er, ce_rand;
  logic [15:0] lp_divisor, dv;
  int n_mismatch = 0, n_compared = 0, n_det = 0, n_tick = 0, seed = 32'h17fc;
  int g, nd, base;

  uirlp_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sir_in(sir_in), .sir_lp_mode(sir_lp_mode), .lp_baud_tick(lp_baud_tick),
    .lp_clk_enabled(lp_clk_enabled), .sir_pulse_detected(sir_pulse_detected),
    .settle_busy(settle_busy), .lp_divisor(lp_divisor));
  uirlp_ir_xcvr xcvr_u (.pclk(pclk), .go(go), .width(width), .sir_in(sir_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // clock enable drops at random while ce_rand is set, adding wait states
  always @(posedge pclk) ce <= !ce_rand || 1'($random(seed));

  always @(negedge pclk) begin
    if (sir_pulse_detected === 1'b1) n_det++;
    if (lp_baud_tick === 1'b1) n_tick++;
  end

  // ----------------------------------------------------------------
  // checks and bus cycles
  // ----------------------------------------------------------------
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    chk_bit(n < 40, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // divisor for the target baud, rounded to nearest
  function automatic logic [15:0] calc_div(input int f, input int baud);
    return 16'((f + 8 * baud) / (16 * baud));
  endfunction : calc_div

  task setdiv(input logic [15:0] d);
    apb(1'b1, uirlp_pkg::DIV_LO_ADDR, {24'h0000_00, d[7:0]}, 4'h1);
    chk_bit(er, 1'b0);
    apb(1'b1, uirlp_pkg::DIV_HI_ADDR, {24'h0000_00, d[15:8]}, 4'h1);
    chk_bit(er, 1'b0);
    @(negedge pclk);
    chk_bit(settle_busy, 1'b1);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk_bit(settle_busy, 1'b0);
  endtask : setdiv

  task tick_gap(output int gap);
    int n;
    n = 0;
    @(negedge pclk);
    while (lp_baud_tick !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    gap = 1;
    @(negedge pclk);
    while (lp_baud_tick !== 1'b1 && gap < 3000) begin
      @(negedge pclk);
      gap++;
    end
  endtask : tick_gap

  task pulse(input logic mode, input logic [7:0] w, output int cnt);
    @(posedge pclk);
    sir_lp_mode <= mode;
    base = n_det;
    @(posedge pclk);
    go <= 1'b1;
    width <= w;
    @(posedge pclk);
    go <= 1'b0;
    repeat (w + 30) @(posedge pclk);
    cnt = n_det - base;
  endtask : pulse

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, sir_lp_mode, go} = 6'h00;
    {paddr, pwdata, pstrb, width, ce_rand} = {32'h0, 32'h0, 4'h0, 8'h00, 1'b0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_val({16'h0000, lp_divisor}, 32'h0000_0000);
    chk_bit(lp_clk_enabled, 1'b0);
    apb(1'b0, uirlp_pkg::DIV_LO_ADDR, 32'h0, 4'h0);
    chk_bit(er, 1'b1);
    apb(1'b1, uirlp_pkg::DIV_HI_ADDR, 32'h0000_0055, 4'h1);
    chk_bit(er, 1'b1);
    chk_val({16'h0000, lp_divisor}, 32'h0000_0000);
    apb(1'b0, 32'h5000_1100, 32'h0, 4'h0);
    chk_bit(er, 1'b1);
    apb(1'b1, uirlp_pkg::LINE_CTRL_ADDR, 32'h0000_0080, 4'h1);
    apb(1'b0, uirlp_pkg::DIV_HI_ADDR, 32'h0, 4'h0);
    chk_val(rd, 32'h0000_0000);
    $display("test reset done");
    {lo, hi} = 16'h0000;
    ce_rand = 1'b1;
    for (int i = 0; i < 10; i++) begin
      wd = (i == 0) ? 32'hffff_ffff : $random(seed);
      st = (i < 2) ? 4'h1 : 4'($random(seed));
      b = wd[7:0];
      if (i % 2 == 0) begin
        apb(1'b1, uirlp_pkg::DIV_LO_ADDR, wd, st);
        if (st[0]) lo = b;
      end else begin
        apb(1'b1, uirlp_pkg::DIV_HI_ADDR, wd, st);
        if (st[0]) hi = b;
      end
      apb(1'b0, uirlp_pkg::DIV_LO_ADDR, 32'h0, 4'h0);
      chk_val(rd, {24'h0000_00, lo});
      apb(1'b0, uirlp_pkg::DIV_HI_ADDR, 32'h0, 4'h0);
      chk_val(rd, {24'h0000_00, hi});
      chk_val({16'h0000, lp_divisor}, {16'h0000, hi, lo});
    end
    ce_rand = 1'b0;
    $display("test registers done");
    dv = calc_div(40_000_000, 115_200);
    setdiv(dv);
    tick_gap(g);
    chk_val(g, 16 * dv);
    dv = 16'(1 + ($random(seed) & 3));
    setdiv(dv);
    tick_gap(g);
    chk_val(g, 16 * dv);
    $display("test baud done");
    setdiv(16'h0002);
    pulse(1'b1, 8'h03, nd);
    chk_val(nd, 0);
    pulse(1'b1, 8'h18, nd);
    chk_val(nd, 1);
    pulse(1'b0, 8'h03, nd);
    chk_val(nd, 1);
    apb(1'b0, uirlp_pkg::STATUS_ADDR, 32'h0, 4'h0);
    chk_val(rd, (32'h1 << uirlp_pkg::STAT_SEEN_BIT) | (32'h1 << uirlp_pkg::STAT_CLK_ON_BIT));
    apb(1'b0, uirlp_pkg::STATUS_ADDR, 32'h0, 4'h0);
    chk_val(rd, 32'h1 << uirlp_pkg::STAT_CLK_ON_BIT);
    $display("test pulse done");
    setdiv(16'h0000);
    chk_bit(lp_clk_enabled, 1'b0);
    base = n_tick;
    repeat (200) @(posedge pclk);
    chk_val(n_tick - base, 0);
    pulse(1'b0, 8'h18, nd);
    chk_val(nd, 0);
    apb(1'b0, uirlp_pkg::STATUS_ADDR, 32'h0, 4'h0);
    chk_val(rd, 32'h0000_0000);
    $display("test zero divisor done");
    apb(1'b1, uirlp_pkg::LINE_CTRL_ADDR, 32'h0, 4'h1);
    apb(1'b1, uirlp_pkg::DIV_LO_ADDR, 32'h0000_0011, 4'h1);
    chk_bit(er, 1'b1);
    chk_val({16'h0000, lp_divisor}, 32'h0000_0000);
    $display("test latch closed done");
    end_of_test;
  end
endmodule : uirlp_top_bench
